//--- logic/variable_duty_pulse_output.v
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pulse_out_map.vh"

module variable_duty_pulse_output #(
	parameter RW = 20,
	parameter AW = 8
) (
	input  wire          i_mclk,
	input  wire          i_rst_n,
	input  wire          i_ce,
	input  wire [1:0]    i_hsc_status1,
	input  wire [1:0]    i_hsc_status2,
	input  wire          i_awvalid,
	output wire          o_awready,
	input  wire [AW-1:0] i_awaddr,
	input  wire [2:0]    i_awprot,
	input  wire          i_wvalid,
	output wire          o_wready,
	input  wire [31:0]   i_wdata,
	input  wire [3:0]    i_wstrb,
	output reg           o_bvalid,
	input  wire          i_bready,
	output reg  [1:0]    o_bresp,
	input  wire          i_arvalid,
	output wire          o_arready,
	input  wire [AW-1:0] i_araddr,
	input  wire [2:0]    i_arprot,
	output reg           o_rvalid,
	input  wire          i_rready,
	output reg  [31:0]   o_rdata,
	output reg  [1:0]    o_rresp,
	output wire          o_pulse1,
	output wire          o_pulse2
);

	localparam integer TICK_DIV = `VDP_CLK_HZ / `VDP_SRC_HZ;
	localparam integer TICK_LAST = TICK_DIV - 1;
	localparam [8:0]   TICK_TOP  = TICK_LAST[8:0];
	localparam [1:0]   RESP_OK  = 2'h0;
	localparam [1:0]   RESP_ERR = 2'h2;

	// Truncated quotient, so the real rate is the source rate over this ratio
	function [RW-1:0] div_ratio;
		input [15:0] freq;
		reg   [31:0] q;
		begin
			q = `VDP_SRC_HZ / {16'h0000, freq};
			div_ratio = q[RW-1:0];
		end
	endfunction

	function [RW-1:0] high_ticks;
		input [RW-1:0] ratio;
		input [7:0]    duty;
		reg   [31:0]   p;
		begin
			p = ({{(32-RW){1'b0}}, ratio} * {24'h000000, duty}) / `VDP_DUTY_MAX;
			high_ticks = p[RW-1:0];
		end
	endfunction

	function [15:0] strb16;
		input [15:0] old;
		input [31:0] data;
		input [3:0]  strb;
		begin
			strb16[7:0]  = strb[0] ? data[7:0] : old[7:0];
			strb16[15:8] = strb[1] ? data[15:8] : old[15:8];
		end
	endfunction

	function mapped;
		input [AW-1:0] a;
		begin
			case (a)
			`VDP_OFF_SET1, `VDP_OFF_SET2, `VDP_OFF_MODE, `VDP_OFF_CMD,
			`VDP_OFF_FREQ, `VDP_OFF_DUTY, `VDP_OFF_STATRD, `VDP_OFF_ERR,
			`VDP_OFF_STAT1, `VDP_OFF_STAT2:
				mapped = 1'b1;
			default:
				mapped = 1'b0;
			endcase
		end
	endfunction

	// Software registers
	reg [15:0] port1_setting_word;
	reg [15:0] port2_setting_word;
	reg        prog_state;
	reg        port_mode;
	reg [15:0] freq_word;
	reg [7:0]  duty_word;
	reg [7:0]  err_code;
	reg [15:0] statrd_word;
	reg        done1;
	reg        done2;

	// Bus holding state
	reg          aw_hold;
	reg          w_hold;
	reg [AW-1:0] aw_addr;
	reg [31:0]   w_data;
	reg [3:0]    w_strb;

	// 500 kHz source tick
	reg [8:0] tick_cnt;
	reg       tick;

	wire busy1;
	wire busy2;

	assign o_awready = i_ce && !aw_hold && !o_bvalid;
	assign o_wready  = i_ce && !w_hold && !o_bvalid;
	assign o_arready = i_ce && !o_rvalid;

	wire aw_fire = i_awvalid && o_awready;
	wire w_fire  = i_wvalid && o_wready;
	wire ar_fire = i_arvalid && o_arready;
	wire wr_go   = i_ce && aw_hold && w_hold && !o_bvalid;

	wire cmd_wr = wr_go && (aw_addr == `VDP_OFF_CMD);
	wire [2:0] cmd_code = w_data[`VDP_CMD_CODE_HI:`VDP_CMD_CODE_LO];
	wire [1:0] cmd_port = w_data[`VDP_CMD_PORT_HI:`VDP_CMD_PORT_LO];
	wire port_ok = (cmd_port == `VDP_PORT_1) || (cmd_port == `VDP_PORT_2);

	wire [15:0] sel_set = (cmd_port == `VDP_PORT_1) ? port1_setting_word : port2_setting_word;
	wire param_ok = (freq_word != 16'h0000) && (freq_word <= `VDP_FREQ_MAX_HZ)
		&& (duty_word <= `VDP_DUTY_MAX);
	// Port mode is not consulted: duty output behaves the same in both
	wire start_cmd = cmd_wr && (cmd_code == `VDP_CODE_START);
	wire start_ok  = start_cmd && port_ok && !prog_state && param_ok
		&& (sel_set == `VDP_SET_VARDUTY);
	wire stop_cmd  = cmd_wr && (cmd_code == `VDP_CODE_STOP) && port_ok;
	wire stat_cmd  = cmd_wr && (cmd_code == `VDP_CODE_STATRD);
	wire bad_cmd   = cmd_wr && !port_ok;

	wire prog_enter = wr_go && (aw_addr == `VDP_OFF_MODE) && w_strb[0]
		&& w_data[`VDP_MODE_PROG] && !prog_state;
	wire abort = prog_enter && (busy1 || busy2);

	wire load1 = start_ok && (cmd_port == `VDP_PORT_1);
	wire load2 = start_ok && (cmd_port == `VDP_PORT_2);
	wire stop1 = (stop_cmd && (cmd_port == `VDP_PORT_1)) || prog_enter;
	wire stop2 = (stop_cmd && (cmd_port == `VDP_PORT_2)) || prog_enter;

	wire [RW-1:0] ratio = div_ratio(freq_word);
	wire [RW-1:0] high  = high_ticks(ratio, duty_word);

	// Live status words; deceleration and pulse count never apply to duty output
	wire [15:0] stat1 = {busy1, done1, 1'b0, 1'b0, 12'h000};
	wire [15:0] stat2 = {busy2, done2, 1'b0, 1'b0, 12'h000};
	wire [15:0] sel_stat = (cmd_port == `VDP_PORT_1) ? stat1 : stat2;
	wire [1:0]  sel_hsc  = (cmd_port == `VDP_PORT_1) ? i_hsc_status1 : i_hsc_status2;

	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			tick_cnt <= 9'h000;
			tick     <= 1'b0;
		end else if (i_ce) begin
			tick <= (tick_cnt == TICK_TOP);
			if (tick_cnt == TICK_TOP)
				tick_cnt <= 9'h000;
			else
				tick_cnt <= tick_cnt + 9'h001;
		end
	end

	// Write address and data are taken in either order and joined here
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			aw_hold  <= 1'b0;
			w_hold   <= 1'b0;
			aw_addr  <= {AW{1'b0}};
			w_data   <= 32'h00000000;
			w_strb   <= 4'h0;
			o_bvalid <= 1'b0;
			o_bresp  <= RESP_OK;
		end else if (i_ce) begin
			if (aw_fire) begin
				aw_hold <= 1'b1;
				aw_addr <= i_awaddr;
			end
			if (w_fire) begin
				w_hold <= 1'b1;
				w_data <= i_wdata;
				w_strb <= i_wstrb;
			end
			if (wr_go) begin
				aw_hold  <= 1'b0;
				w_hold   <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp  <= mapped(aw_addr) ? RESP_OK : RESP_ERR;
			end else if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
			end
		end
	end

	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			port1_setting_word <= `VDP_SET_RESET;
			port2_setting_word <= `VDP_SET_RESET;
			prog_state         <= 1'b0;
			port_mode          <= 1'b0;
			freq_word          <= 16'h0000;
			duty_word          <= 8'h00;
		end else if (i_ce && wr_go) begin
			case (aw_addr)
			`VDP_OFF_SET1: begin
				// Setup is only taken in the programming state
				if (prog_state)
					port1_setting_word <= strb16(port1_setting_word, w_data, w_strb);
			end
			`VDP_OFF_SET2: begin
				if (prog_state)
					port2_setting_word <= strb16(port2_setting_word, w_data, w_strb);
			end
			`VDP_OFF_MODE: begin
				if (w_strb[0]) begin
					prog_state <= w_data[`VDP_MODE_PROG];
					port_mode  <= w_data[`VDP_MODE_PORT];
				end
			end
			`VDP_OFF_FREQ: begin
				freq_word <= strb16(freq_word, w_data, w_strb);
			end
			`VDP_OFF_DUTY: begin
				if (w_strb[0])
					duty_word <= w_data[7:0];
			end
			default: begin
			end
			endcase
		end
	end

	// Completion is set by a halt and cleared by a fresh start on that port
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			done1 <= 1'b0;
			done2 <= 1'b0;
		end else if (i_ce) begin
			if (stop1 && busy1)
				done1 <= 1'b1;
			else if (load1)
				done1 <= 1'b0;
			if (stop2 && busy2)
				done2 <= 1'b1;
			else if (load2)
				done2 <= 1'b0;
		end
	end

	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			err_code <= `VDP_ERR_NORMAL;
		end else if (i_ce) begin
			if (abort)
				err_code <= `VDP_ERR_STOPPED;
			else if (bad_cmd || (start_cmd && !start_ok))
				err_code <= `VDP_ERR_SETUP;
			else if (start_ok)
				err_code <= `VDP_ERR_NORMAL;
		end
	end

	// Snapshot taken when the command executes, not on any periodic scan
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			statrd_word <= 16'h0000;
		end else if (i_ce && stat_cmd && port_ok) begin
			statrd_word <= {8'h00, sel_stat[`VDP_ST_RUN:`VDP_ST_DECEL], 2'b00, sel_hsc};
		end
	end

	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_rvalid <= 1'b0;
			o_rdata  <= 32'h00000000;
			o_rresp  <= RESP_OK;
		end else if (i_ce) begin
			if (ar_fire) begin
				o_rvalid <= 1'b1;
				o_rresp  <= mapped(i_araddr) ? RESP_OK : RESP_ERR;
				case (i_araddr)
				`VDP_OFF_SET1:   o_rdata <= {16'h0000, port1_setting_word};
				`VDP_OFF_SET2:   o_rdata <= {16'h0000, port2_setting_word};
				`VDP_OFF_MODE:   o_rdata <= {30'h0, port_mode, prog_state};
				`VDP_OFF_FREQ:   o_rdata <= {16'h0000, freq_word};
				`VDP_OFF_DUTY:   o_rdata <= {24'h000000, duty_word};
				`VDP_OFF_STATRD: o_rdata <= {16'h0000, statrd_word};
				`VDP_OFF_ERR:    o_rdata <= {16'h0000, err_code, 8'h00};
				`VDP_OFF_STAT1:  o_rdata <= {16'h0000, stat1};
				`VDP_OFF_STAT2:  o_rdata <= {16'h0000, stat2};
				default:         o_rdata <= 32'h00000000;
				endcase
			end else if (o_rvalid && i_rready) begin
				o_rvalid <= 1'b0;
			end
		end
	end

	pulse_channel #(
		.RW (RW)
	) u_port1 (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_ce    (i_ce),
		.i_tick  (tick),
		.i_load  (load1),
		.i_stop  (stop1),
		.i_ratio (ratio),
		.i_high  (high),
		.o_pulse (o_pulse1),
		.o_busy  (busy1)
	);

	pulse_channel #(
		.RW (RW)
	) u_port2 (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_ce    (i_ce),
		.i_tick  (tick),
		.i_load  (load2),
		.i_stop  (stop2),
		.i_ratio (ratio),
		.i_high  (high),
		.o_pulse (o_pulse2),
		.o_busy  (busy2)
	);

endmodule

//--- logic/pulse_out_map.vh
`ifndef PULSE_OUT_MAP_VH
`define PULSE_OUT_MAP_VH

`define VDP_OFF_SET1      8'h00
`define VDP_OFF_SET2      8'h04
`define VDP_OFF_MODE      8'h08
`define VDP_OFF_CMD       8'h0c
`define VDP_OFF_FREQ      8'h10
`define VDP_OFF_DUTY      8'h14
`define VDP_OFF_STATRD    8'h18
`define VDP_OFF_ERR       8'h1c
`define VDP_OFF_STAT1     8'h20
`define VDP_OFF_STAT2     8'h24

`define VDP_SET_VARDUTY   16'h1000
`define VDP_SET_RESET     16'h0000

`define VDP_MODE_PROG     0
`define VDP_MODE_PORT     1

`define VDP_CMD_CODE_LO   0
`define VDP_CMD_CODE_HI   2
`define VDP_CMD_PORT_LO   8
`define VDP_CMD_PORT_HI   9
`define VDP_CODE_STATRD   3'h1
`define VDP_CODE_STOP     3'h3
`define VDP_CODE_START    3'h4
`define VDP_PORT_1        2'h1
`define VDP_PORT_2        2'h2

`define VDP_ERR_LO        8
`define VDP_ERR_NORMAL    8'h00
`define VDP_ERR_SETUP     8'h02
`define VDP_ERR_STOPPED   8'h03

`define VDP_ST_DECEL      12
`define VDP_ST_COUNT      13
`define VDP_ST_DONE       14
`define VDP_ST_RUN        15
`define VDP_RD_HSC_LO     0
`define VDP_RD_DECEL      4

`define VDP_CLK_HZ        200000000
`define VDP_SRC_HZ        500000
`define VDP_FREQ_MAX_HZ   50000
`define VDP_DUTY_MAX      100

`endif

//--- logic/pulse_channel.v
`timescale 1ns/1ps
// One pulse output: counts source ticks over a period of ratio ticks, high for the first high ticks.
module pulse_channel #(
	parameter RW = 20
) (
	input  wire          i_mclk,
	input  wire          i_rst_n,
	input  wire          i_ce,
	input  wire          i_tick,
	input  wire          i_load,
	input  wire          i_stop,
	input  wire [RW-1:0] i_ratio,
	input  wire [RW-1:0] i_high,
	output reg           o_pulse,
	output reg           o_busy
);

	reg [RW-1:0] cnt;
	reg [RW-1:0] ratio;
	reg [RW-1:0] high;
	reg [RW-1:0] pend_ratio;
	reg [RW-1:0] pend_high;
	reg          pend;

	wire [RW-1:0] cnt_inc = cnt + {{(RW-1){1'b0}}, 1'b1};
	wire          wrap    = (cnt_inc >= ratio);

	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			cnt        <= {RW{1'b0}};
			ratio      <= {RW{1'b0}};
			high       <= {RW{1'b0}};
			pend_ratio <= {RW{1'b0}};
			pend_high  <= {RW{1'b0}};
			pend       <= 1'b0;
			o_pulse    <= 1'b0;
			o_busy     <= 1'b0;
		end else if (i_ce) begin
			if (i_stop) begin
				o_busy  <= 1'b0;
				o_pulse <= 1'b0;
				pend    <= 1'b0;
				cnt     <= {RW{1'b0}};
			end else if (i_load && !o_busy) begin
				o_busy  <= 1'b1;
				ratio   <= i_ratio;
				high    <= i_high;
				cnt     <= {RW{1'b0}};
				o_pulse <= (i_high != {RW{1'b0}});
			end else begin
				if (i_load) begin
					// Held until the period ends so the running pulse is never cut short
					pend_ratio <= i_ratio;
					pend_high  <= i_high;
					pend       <= 1'b1;
				end
				if (o_busy && i_tick) begin
					if (wrap) begin
						cnt <= {RW{1'b0}};
						if (pend && !i_load) begin
							ratio   <= pend_ratio;
							high    <= pend_high;
							pend    <= 1'b0;
							o_pulse <= (pend_high != {RW{1'b0}});
						end else begin
							o_pulse <= (high != {RW{1'b0}});
						end
					end else begin
						cnt     <= cnt_inc;
						o_pulse <= (cnt_inc < high);
					end
				end
			end
		end
	end

endmodule

//--- verif/pulse_load.sv
`timescale 1ns/1ps
// Load on one pulse output: measures period and high time in clocks
module pulse_load (
	input  wire logic i_mclk,
	input  wire logic i_pulse,
	output int        o_period,
	output int        o_high,
	output int        o_rises
);
	int   cnt = 0;
	logic last = 0;
	initial begin
		o_period = 0;
		o_high = 0;
		o_rises = 0;
	end
	// First period after a start is meaningless, the bench skips it
	always @(posedge i_mclk) begin
		last <= i_pulse;
		cnt <= (i_pulse && !last) ? 1 : cnt + 1;
		if (i_pulse && !last) begin
			o_period <= cnt;
			o_rises <= o_rises + 1;
		end
		if (!i_pulse && last)
			o_high <= cnt;
	end
endmodule

//--- verif/variable_duty_pulse_output_chk.sv
`timescale 1ns/1ps
`include "pulse_out_map.vh"
module vdp_port_chk #(
	parameter AW = 8
) (
	input wire          i_mclk,
	input wire          i_rst_n,
	input wire          i_ce,
	input wire          i_awvalid,
	input wire          o_awready,
	input wire [AW-1:0] i_awaddr,
	input wire          i_wvalid,
	input wire          o_wready,
	input wire [31:0]   i_wdata,
	input wire          o_bvalid,
	input wire          i_bready,
	input wire [1:0]    o_bresp,
	input wire          i_arvalid,
	input wire          o_arready,
	input wire [AW-1:0] i_araddr,
	input wire          o_rvalid,
	input wire          i_rready,
	input wire [31:0]   o_rdata,
	input wire [1:0]    o_rresp,
	input wire          o_pulse1
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);
	wr_resp_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("write response dropped early");
	rd_data_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
		else $error("read data dropped early");
	rd_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid)
		else $error("read not answered next cycle");
	wr_block_a: assert property (o_bvalid |-> !o_awready && !o_wready)
		else $error("write taken while response pending");
	ce_gate_a: assert property (!i_ce |-> !o_awready && !o_wready && !o_arready)
		else $error("ready while clock enable low");
	rd_unmapped_a: assert property (i_arvalid && o_arready && i_araddr > 8'h24 |=> o_rresp == 2'h2 && o_rdata == 0)
		else $error("unmapped read not refused");
	stop_low_a: assert property (i_awvalid && o_awready && i_wvalid && o_wready && i_awaddr == `VDP_OFF_CMD
		&& i_wdata[9:0] == 10'h103 |-> ##3 !o_pulse1)
		else $error("pulse still high after stop");
	err_field_a: assert property (o_rvalid && !$past(o_rvalid) && $past(i_araddr) == `VDP_OFF_ERR
		|-> o_rdata[7:0] == 0 && o_rdata[31:16] == 0)
		else $error("error word has bits outside code field");
	stat_field_a: assert property (o_rvalid && !$past(o_rvalid) && $past(i_araddr) == `VDP_OFF_STATRD
		|-> o_rdata[31:8] == 0 && o_rdata[3:2] == 0)
		else $error("status result has stray bits");
endmodule

bind variable_duty_pulse_output vdp_port_chk #(.AW(AW)) u_chk (.i_mclk, .i_rst_n, .i_ce, .i_awvalid, .o_awready,
	.i_awaddr, .i_wvalid, .o_wready, .i_wdata, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr,
	.o_rvalid, .i_rready, .o_rdata, .o_rresp, .o_pulse1);

//--- verif/variable_duty_pulse_output_bench.sv
`timescale 1ns/1ps
`include "pulse_out_map.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; $display("mismatch at %0t: got %0h expected %0h", $time, g, e); end end
module variable_duty_pulse_output_bench;
	logic        i_mclk = 0, i_rst_n = 0, i_ce = 1;
	logic [1:0]  i_hsc_status1 = 0, i_hsc_status2 = 0;
	logic        i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
	logic [7:0]  i_awaddr = 0, i_araddr = 0;
	logic [2:0]  i_awprot = 0, i_arprot = 0;
	logic [31:0] i_wdata = 0, q;
	logic [3:0]  i_wstrb = 4'hf;
	logic [1:0]  r;
	wire         o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_pulse1, o_pulse2;
	wire  [1:0]  o_bresp, o_rresp;
	wire  [31:0] o_rdata;
	int          n_errors = 0, n_tests = 0;
	int          per1, hi1, rise1, per2, hi2, rise2;
	int          run[3], done[3];
	int          fl[4] = '{50000, 45455, 33333, 20000};

	variable_duty_pulse_output DUT (.i_mclk, .i_rst_n, .i_ce, .i_hsc_status1, .i_hsc_status2, .i_awvalid,
		.o_awready, .i_awaddr, .i_awprot, .i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready,
		.o_bresp, .i_arvalid, .o_arready, .i_araddr, .i_arprot, .o_rvalid, .i_rready, .o_rdata, .o_rresp,
		.o_pulse1, .o_pulse2);
	pulse_load load1 (.i_mclk, .i_pulse(o_pulse1), .o_period(per1), .o_high(hi1), .o_rises(rise1));
	pulse_load load2 (.i_mclk, .i_pulse(o_pulse2), .o_period(per2), .o_high(hi2), .o_rises(rise2));

	initial begin
		forever #2.5 i_mclk = ~i_mclk;
	end

	function automatic int per_of(int f);
		return `VDP_SRC_HZ / f * (`VDP_CLK_HZ / `VDP_SRC_HZ);
	endfunction
	function automatic int hi_of(int f, int d);
		return `VDP_SRC_HZ / f * d / 100 * (`VDP_CLK_HZ / `VDP_SRC_HZ);
	endfunction

	// Readiness is looked at on the falling edge, so it is the value the next rising edge sees
	task automatic bus(input bit wr, input [7:0] a, input [31:0] d, output [31:0] rq, output [1:0] rr);
		bit ta, tw, t, x, late;
		late = $urandom % 2;
		@(posedge i_mclk);
		if (wr) begin
			i_awvalid <= 1;
			i_wvalid <= 1;
			i_awaddr <= a;
			i_wdata <= d;
			i_bready <= !late;
		end else begin
			i_arvalid <= 1;
			i_araddr <= a;
			i_rready <= !late;
		end
		ta = 0;
		tw = !wr;
		while (!(ta && tw)) begin
			@(negedge i_mclk);
			t = wr ? (i_awvalid && o_awready) : (i_arvalid && o_arready);
			x = i_wvalid && o_wready;
			@(posedge i_mclk);
			if (t) begin
				ta = 1;
				i_awvalid <= 0;
				i_arvalid <= 0;
			end
			if (wr && x) begin
				tw = 1;
				i_wvalid <= 0;
			end
		end
		do @(negedge i_mclk); while (!(wr ? o_bvalid : o_rvalid));
		if (late) begin
			// Answer left waiting one edge so the slave has to hold it
			@(posedge i_mclk);
			i_bready <= wr;
			i_rready <= !wr;
			@(negedge i_mclk);
		end
		rq = o_rdata;
		rr = wr ? o_bresp : o_rresp;
		@(posedge i_mclk);
		i_bready <= 0;
		i_rready <= 0;
	endtask

	task automatic wr(input [7:0] a, input [31:0] d);
		bus(1, a, d, q, r);
		`CHK(r, 2'h0)
	endtask
	task automatic rd(input [7:0] a, input [31:0] e);
		bus(0, a, 0, q, r);
		`CHK(q, e)
	endtask
	task automatic cmd(input [2:0] c, input [1:0] p, input int f, input int d);
		if (c == `VDP_CODE_START) begin
			wr(`VDP_OFF_FREQ, f);
			wr(`VDP_OFF_DUTY, d);
		end
		wr(`VDP_OFF_CMD, {22'h0, p, 5'h0, c});
	endtask
	task automatic stat(input int p);
		i_hsc_status1 <= $urandom;
		i_hsc_status2 <= $urandom;
		@(posedge i_mclk);
		rd(p == 1 ? `VDP_OFF_STAT1 : `VDP_OFF_STAT2, run[p] << 15 | done[p] << 14);
		cmd(`VDP_CODE_STATRD, p, 0, 0);
		rd(`VDP_OFF_STATRD, run[p] << 7 | done[p] << 6 | (p == 1 ? i_hsc_status1 : i_hsc_status2));
	endtask

	task end_of_test;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Longest path is two rounds of about three periods at the lowest frequency used
	initial begin
		repeat (90000) @(posedge i_mclk);
		n_errors++;
		$display("mismatch at %0t: timeout", $time);
		end_of_test;
	end

	initial begin
		int f1, f2, d1, d2, d3, r1, r2, rl;
		void'($urandom(18069));
		repeat (16) @(posedge i_mclk);
		i_rst_n <= 1;
		rd(`VDP_OFF_ERR, 0);
		stat(1);
		bus(0, 8'h40, 0, q, r);
		`CHK(r, 2'h2)
		i_ce <= 0;
		repeat (3) @(posedge i_mclk);
		i_ce <= 1;
		wr(`VDP_OFF_SET1, `VDP_SET_VARDUTY);
		rd(`VDP_OFF_SET1, 0);
		cmd(`VDP_CODE_START, 1, 20000, 50);
		rd(`VDP_OFF_ERR, 32'h200);
		`CHK(rise1, 0)
		wr(`VDP_OFF_MODE, 1);
		wr(`VDP_OFF_SET1, `VDP_SET_VARDUTY);
		wr(`VDP_OFF_SET2, `VDP_SET_VARDUTY);
		rd(`VDP_OFF_SET1, `VDP_SET_VARDUTY);
		wr(`VDP_OFF_MODE, ($urandom % 2) << 1);
		f1 = fl[$urandom % 4];
		f2 = fl[$urandom % 4];
		d1 = 10 + $urandom % 81;
		d2 = 10 + $urandom % 81;
		d3 = 10 + $urandom % 81;
		r1 = rise1;
		r2 = rise2;
		cmd(`VDP_CODE_START, 1, f1, d1);
		cmd(`VDP_CODE_START, 2, f2, d2);
		run[1] = 1;
		run[2] = 1;
		rd(`VDP_OFF_ERR, 0);
		while (rise1 < r1 + 3 || rise2 < r2 + 3) @(posedge i_mclk);
		`CHK(per1, per_of(f1))
		`CHK(hi1, hi_of(f1, d1))
		`CHK(per2, per_of(f2))
		`CHK(hi2, hi_of(f2, d2))
		stat(1);
		rl = rise1;
		cmd(`VDP_CODE_START, 1, f1, d3);
		r1 = rise1;
		while (rise1 < r1 + 3) begin
			@(posedge i_mclk);
			if (rise1 != rl) `CHK(hi1 == hi_of(f1, d1) || hi1 == hi_of(f1, d3), 1'b1)
			rl = rise1;
		end
		`CHK(hi1, hi_of(f1, d3))
		`CHK(per1, per_of(f1))
		`CHK(hi2, hi_of(f2, d2))
		cmd(`VDP_CODE_STOP, 1, 0, 0);
		run[1] = 0;
		done[1] = 1;
		@(negedge i_mclk);
		`CHK(o_pulse1, 1'b0)
		r1 = rise1;
		stat(1);
		cmd(`VDP_CODE_STOP, 3, 0, 0);
		rd(`VDP_OFF_ERR, 32'h200);
		wr(`VDP_OFF_MODE, 1);
		run[2] = 0;
		done[2] = 1;
		rd(`VDP_OFF_ERR, 32'h300);
		stat(2);
		@(negedge i_mclk);
		`CHK(o_pulse2, 1'b0)
		`CHK(rise1, r1)
		end_of_test;
	end
endmodule
